//--- e3tx_map.vh
// Purpose: Constants for the E3 transmit line encoder
// Assumes: Included by the line encoder design file only
// Notes:   Definitions only
`ifndef E3TX_MAP_VH
`define E3TX_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define E3TX_ADDR_IO_CTRL      8'h01
`define E3TX_ADDR_STATUS       8'h02

// ****************************************************************
// Line control register layout and reset
// ****************************************************************
`define E3TX_IO_CTRL_RESET     8'hA0
`define E3TX_IO_CTRL_WMASK     8'hBF
`define E3TX_BIT_TX_LOC_DIS    7
`define E3TX_BIT_LOC           6
`define E3TX_BIT_RX_LOC_DIS    5
`define E3TX_BIT_PLAIN_AMI     4
`define E3TX_BIT_UNIPOLAR      3
`define E3TX_BIT_TX_CLK_INV    2
`define E3TX_BIT_RX_CLK_INV    1
`define E3TX_BIT_REFRAME       0

// ****************************************************************
// Status register layout
// ****************************************************************
`define E3TX_ST_FIFO_EMPTY     0
`define E3TX_ST_FIFO_FULL      1
`define E3TX_ST_LAST_POS       2
`define E3TX_ST_PARITY         3
`define E3TX_ST_LINE_LEVEL     4
`define E3TX_ST_UNDERRUN       5

// ****************************************************************
// Symbol codes and buffer shape
// ****************************************************************
`define E3TX_SYM_ZERO          2'h0
`define E3TX_SYM_MARK          2'h1
`define E3TX_SYM_BPULSE        2'h2
`define E3TX_SYM_VIOL          2'h3
`define E3TX_FIFO_WIDTH        2
`define E3TX_FIFO_DEPTH        8
`define E3TX_FIFO_AW           3

`endif

//--- e3tx_fifo.v
// Purpose: Small FIFO for the outbound bit stream
// Assumes: DEPTH is a power of two, AW = log2(DEPTH)
// Notes:   Flags are registered; read data is combinational
`timescale 1ns/1ps

module e3tx_fifo #(
	parameter WIDTH = 2,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and control
	input  wire             clk,
	input  wire             rst_n,
	input  wire             ce,
	// Fill side
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output reg              in_ready,
	// Drain side
	output wire [WIDTH-1:0] out_data,
	output reg              out_valid,
	input  wire             out_ready
);

	localparam [AW:0] FULL_LEVEL = DEPTH;

	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr;
	reg  [AW-1:0]    rd_ptr;
	reg  [AW:0]      level;
	reg  [AW:0]      next_level;
	wire             push;
	wire             pop;

	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;
	assign out_data = mem[rd_ptr];

	always @* begin
		next_level = level;
		if (push & ~pop)
			next_level = level + 1'b1;
		else if (pop & ~push)
			next_level = level - 1'b1;
	end

	always @(posedge clk) begin
		if (ce & push)
			mem[wr_ptr] <= in_data;
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr    <= {AW{1'b0}};
			rd_ptr    <= {AW{1'b0}};
			level     <= {(AW+1){1'b0}};
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else if (ce) begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			level     <= next_level;
			in_ready  <= (next_level != FULL_LEVEL);
			out_valid <= (next_level != {(AW+1){1'b0}});
		end
	end

endmodule // e3tx_fifo

//--- e3tx_edge_sync.v
// Purpose: Two-stage synchroniser with edge detection
// Assumes: Input is asynchronous to clk and slower than clk/2
// Notes:   Edge pulses last one clk cycle
`timescale 1ns/1ps

module e3tx_edge_sync (
	// Clock and control
	input  wire clk,
	input  wire rst_n,
	input  wire ce,
	// Asynchronous input
	input  wire async_in,
	// Synchronised level and edges
	output wire level,
	output wire rise,
	output wire fall
);

	reg meta;
	reg held;
	reg prev;

	always @(posedge clk) begin
		if (!rst_n) begin
			meta <= 1'b0;
			held <= 1'b0;
			prev <= 1'b0;
		end else if (ce) begin
			meta <= async_in;
			held <= meta;
			prev <= held;
		end
	end

	assign level = held;
	assign rise  = held & ~prev;
	assign fall  = ~held & prev;

endmodule // e3tx_edge_sync

//--- e3tx_line_encoder.v
// Purpose: E3 transmit line interface: unipolar, AMI or HDB3 rails
// Assumes: Line clock pin is slow against core_clk; framer on core_clk
// Notes:   Four-symbol delay from buffer to rails in every mode
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "e3tx_map.vh"

module e3tx_line_encoder (
	// Clock, reset and enable
	input  wire       core_clk,
	input  wire       rst_n,
	input  wire       core_ce,
	// Register port
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	// Outbound bit stream from the transmit framer
	input  wire       tx_bit_data,
	input  wire       tx_bit_frame_start,
	input  wire       tx_bit_valid,
	output wire       tx_bit_ready,
	// Line clock pin
	input  wire       tx_line_clock_in,
	// Line unit pins
	output reg        tx_positive_rail,
	output reg        tx_negative_rail,
	output reg        tx_line_clock_out,
	// Shared settings for the receive interface
	output wire       rx_unipolar_mode,
	output wire       rx_plain_ami,
	output wire       rx_clock_edge_invert,
	output wire       rx_loc_disable,
	output wire       tx_loc_disable,
	output wire       reframe_request
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	reg  [7:0] io_line_control;
	reg        underrun;
	reg  [7:0] sym_pipe;
	reg  [3:0] frm_pipe;
	reg        last_pos;
	reg        pulse_parity;

	reg        next_pos_rail;
	reg        next_neg_rail;
	reg        next_last_pos;
	reg        next_parity;
	reg  [7:0] next_rdata;

	wire       line_level;
	wire       line_rise;
	wire       line_fall;
	wire       line_tick;

	wire [1:0] fifo_out;
	wire       fifo_valid;
	wire       fifo_in_ready;

	wire       unipolar_mode;
	wire       plain_alternate_mark_select;
	wire       tx_clock_edge_invert;
	wire       use_hdb3;

	wire       new_bit;
	wire       new_frm;
	wire [1:0] sym0;
	wire [1:0] sym1;
	wire [1:0] sym2;
	wire [1:0] sym3;
	wire       zero_run;
	wire       substitute;
	wire       insert_b;
	wire [1:0] stage0_in;
	wire [1:0] stage3_in;
	wire [7:0] status_word;
	wire       wr_ctrl;
	wire       wr_status;

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	assign unipolar_mode               = io_line_control[`E3TX_BIT_UNIPOLAR];
	assign plain_alternate_mark_select = io_line_control[`E3TX_BIT_PLAIN_AMI];
	assign tx_clock_edge_invert = io_line_control[`E3TX_BIT_TX_CLK_INV];

	// Unipolar and AMI settings drive both directions; RX clock edge has its own bit
	assign rx_unipolar_mode     = unipolar_mode;
	assign rx_plain_ami         = plain_alternate_mark_select;
	assign rx_clock_edge_invert = io_line_control[`E3TX_BIT_RX_CLK_INV];
	assign rx_loc_disable       = io_line_control[`E3TX_BIT_RX_LOC_DIS];
	assign tx_loc_disable       = io_line_control[`E3TX_BIT_TX_LOC_DIS];
	assign reframe_request      = io_line_control[`E3TX_BIT_REFRAME];

	// Code bit only counts in bipolar mode
	assign use_hdb3 = ~unipolar_mode
		& ~plain_alternate_mark_select;

	// ****************************************************************
	// Line clock sampling
	// ****************************************************************
	e3tx_edge_sync u_line_sync (
		.clk      (core_clk),
		.rst_n    (rst_n),
		.ce       (core_ce),
		.async_in (tx_line_clock_in),
		.level    (line_level),
		.rise     (line_rise),
		.fall     (line_fall)
	);

	// One bit period per chosen edge
	assign line_tick = tx_clock_edge_invert ? line_fall : line_rise;

	// ****************************************************************
	// Bit buffer
	// ****************************************************************
	e3tx_fifo #(
		.WIDTH (`E3TX_FIFO_WIDTH),
		.DEPTH (`E3TX_FIFO_DEPTH),
		.AW    (`E3TX_FIFO_AW)
	) u_fifo (
		.clk       (core_clk),
		.rst_n     (rst_n),
		.ce        (core_ce),
		.in_data   ({tx_bit_frame_start, tx_bit_data}),
		.in_valid  (tx_bit_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_valid),
		.out_ready (line_tick)
	);

	assign tx_bit_ready = fifo_in_ready;

	// Empty buffer sends an idle zero
	assign new_bit = fifo_valid & fifo_out[0];
	assign new_frm = fifo_valid & fifo_out[1];

	// ****************************************************************
	// Symbol pipeline and zero substitution
	// ****************************************************************
	assign sym0 = sym_pipe[1:0];
	assign sym1 = sym_pipe[3:2];
	assign sym2 = sym_pipe[5:4];
	assign sym3 = sym_pipe[7:6];

	// Incoming zero completes a run of four
	assign zero_run = ~new_bit
		& (sym0 == `E3TX_SYM_ZERO)
		& (sym1 == `E3TX_SYM_ZERO)
		& (sym2 == `E3TX_SYM_ZERO);

	assign substitute = use_hdb3 & zero_run;

	// Even count since last violation needs a B first
	assign insert_b = substitute & ~next_parity;

	assign stage0_in = substitute ? `E3TX_SYM_VIOL :
		(new_bit ? `E3TX_SYM_MARK : `E3TX_SYM_ZERO);
	assign stage3_in = insert_b ? `E3TX_SYM_BPULSE : sym2;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			sym_pipe <= 8'h00;
			frm_pipe <= 4'h0;
		end else if (core_ce & line_tick) begin
			sym_pipe <= {stage3_in, sym_pipe[3:0], stage0_in};
			frm_pipe <= {frm_pipe[2:0], new_frm};
		end
	end

	// ****************************************************************
	// Rail selection for the oldest symbol
	// ****************************************************************
	always @* begin
		next_pos_rail = 1'b0;
		next_neg_rail = 1'b0;
		next_last_pos = last_pos;
		next_parity   = pulse_parity;
		if (unipolar_mode) begin
			// NRZ data, frame marker on the other rail
			next_pos_rail = (sym3 != `E3TX_SYM_ZERO);
			next_neg_rail = frm_pipe[3];
		end else begin
			case (sym3)
			`E3TX_SYM_MARK, `E3TX_SYM_BPULSE: begin
				// Opposite to the last pulse, zeros in between or not
				next_pos_rail = ~last_pos;
				next_neg_rail = last_pos;
				next_last_pos = ~last_pos;
				next_parity   = ~pulse_parity;
			end
			`E3TX_SYM_VIOL: begin
				// Same polarity as the last pulse
				next_pos_rail = last_pos;
				next_neg_rail = ~last_pos;
				next_parity   = 1'b0;
			end
			default: begin
				next_pos_rail = 1'b0;
				next_neg_rail = 1'b0;
			end
			endcase
		end
	end

	// ****************************************************************
	// Polarity state
	// ****************************************************************
	always @(posedge core_clk) begin
		if (!rst_n) begin
			// Last pulse taken as negative so the first goes positive
			last_pos     <= 1'b0;
			pulse_parity <= 1'b0;
		end else if (core_ce & line_tick) begin
			last_pos     <= next_last_pos;
			pulse_parity <= next_parity;
		end
	end

	// ****************************************************************
	// Line unit outputs
	// ****************************************************************
	always @(posedge core_clk) begin
		if (!rst_n) begin
			tx_positive_rail  <= 1'b0;
			tx_negative_rail  <= 1'b0;
			tx_line_clock_out <= 1'b0;
		end else if (core_ce) begin
			// Clock out moves in the same cycle as the rails
			tx_line_clock_out <= line_level;
			if (line_tick) begin
				tx_positive_rail <= next_pos_rail;
				tx_negative_rail <= next_neg_rail;
			end
		end
	end

	// ****************************************************************
	// Register writes
	// ****************************************************************
	assign wr_ctrl   = reg_wr & (reg_addr == `E3TX_ADDR_IO_CTRL);
	assign wr_status = reg_wr & (reg_addr == `E3TX_ADDR_STATUS);

	always @(posedge core_clk) begin
		if (!rst_n) begin
			// Bipolar HDB3 on rising edge after reset
			io_line_control <= `E3TX_IO_CTRL_RESET;
		end else if (core_ce & wr_ctrl) begin
			// Status bit is read-only
			io_line_control <= reg_wdata & `E3TX_IO_CTRL_WMASK;
		end
	end

	// Sticky underrun: new event beats a write-one clear
	always @(posedge core_clk) begin
		if (!rst_n) begin
			underrun <= 1'b0;
		end else if (core_ce) begin
			if (line_tick & ~fifo_valid)
				underrun <= 1'b1;
			else if (wr_status & reg_wdata[`E3TX_ST_UNDERRUN])
				underrun <= 1'b0;
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	assign status_word = {
		2'b00,
		underrun,
		line_level,
		pulse_parity,
		last_pos,
		~fifo_in_ready,
		~fifo_valid
	};

	always @* begin
		next_rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
			`E3TX_ADDR_IO_CTRL: begin
				next_rdata = io_line_control;
			end
			`E3TX_ADDR_STATUS: begin
				next_rdata = status_word;
			end
			default: begin
				next_rdata = 8'h00;
			end
			endcase
		end
	end

	// Data stand only in the cycle after the strobe
	always @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (core_ce) begin
			reg_rdata <= next_rdata;
		end
	end

endmodule // e3tx_line_encoder

//--- e3tx_line_encoder_sva.sv
// Purpose: Port checks for the E3 transmit line encoder
// Assumes: core_ce held high
// Notes:   Bound to every encoder instance
`timescale 1ns/1ps

module e3tx_chk (
	// Clock and reset
	input wire       core_clk,
	input wire       rst_n,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	// Stream and line
	input wire       tx_bit_valid,
	input wire       tx_bit_ready,
	input wire       tx_line_clock_in,
	input wire       tx_positive_rail,
	input wire       tx_negative_rail,
	input wire       tx_line_clock_out,
	// Shared settings
	input wire       rx_unipolar_mode,
	input wire       rx_plain_ami
);
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	property p_rail_excl;
		!rx_unipolar_mode |-> !(tx_positive_rail && tx_negative_rail);
	endproperty
	a_rail_excl: assert property (p_rail_excl) else $error("rail clash");
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_rd_ctrl;
		$past(reg_rd) && $past(reg_addr) == 8'h01 |-> !reg_rdata[6] &&
			reg_rdata[3] == $past(rx_unipolar_mode) &&
			reg_rdata[4] == $past(rx_plain_ami);
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("bad readback");
	property p_wr_ctrl;
		reg_wr && reg_addr == 8'h01 |=> rx_plain_ami == $past(reg_wdata[4]) &&
			rx_unipolar_mode == $past(reg_wdata[3]);
	endproperty
	a_wr_ctrl: assert property (p_wr_ctrl) else $error("mode not taken");
	property p_rail_hold;
		!$stable(tx_positive_rail) || !$stable(tx_negative_rail) |->
			!$stable(tx_line_clock_out);
	endproperty
	a_rail_hold: assert property (p_rail_hold) else $error("rail off tick");
	property p_clk_follow;
		$past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3) |->
			tx_line_clock_out == $past(tx_line_clock_in, 3);
	endproperty
	a_clk_follow: assert property (p_clk_follow) else $error("clock lag");
	property p_ready_fall;
		$fell(tx_bit_ready) |-> $past(tx_bit_valid);
	endproperty
	a_ready_fall: assert property (p_ready_fall) else $error("ready fell");
	property p_ready_rise;
		$rose(tx_bit_ready) |-> !$stable(tx_line_clock_out) ||
			!$past(rst_n) || !$past(rst_n, 2);
	endproperty
	a_ready_rise: assert property (p_ready_rise) else $error("ready rose");
endmodule // e3tx_chk

bind e3tx_line_encoder e3tx_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_bit_valid(tx_bit_valid),
	.tx_bit_ready(tx_bit_ready), .tx_line_clock_in(tx_line_clock_in),
	.tx_positive_rail(tx_positive_rail), .tx_negative_rail(tx_negative_rail),
	.tx_line_clock_out(tx_line_clock_out),
	.rx_unipolar_mode(rx_unipolar_mode), .rx_plain_ami(rx_plain_ami));

//--- e3tx_liu_model.sv
// Purpose: Line unit model: line clock source and rail sampler
// Assumes: Clock idles low between bursts
// Notes:   tick marks the cycle in which rails are taken
`timescale 1ns/1ps

module e3tx_liu_model (
	// Core side
	input wire core_clk,
	input wire run,
	input wire inv,
	// Line pins
	input wire tx_line_clock_out,
	output reg line_clk,
	output wire tick
);
	reg prev;

	initial line_clk = 1'b0;
	// Finishes a started period, then stands still
	always begin
		#80;
		if (run || line_clk)
			line_clk = ~line_clk;
	end
	always @(posedge core_clk)
		prev <= tx_line_clock_out;
	assign tick = tx_line_clock_out != prev && tx_line_clock_out != inv;
endmodule // e3tx_liu_model

//--- tb.sv
// Purpose: Self-checking bench for the E3 transmit line encoder
// Assumes: Line clock stands still between bursts
// Notes:   Model mirrors buffer, four-symbol pipeline and coder
`timescale 1ns/1ps

module tb;
	reg        core_clk = 1'b0;
	reg        rst_n = 1'b0;
	reg  [7:0] reg_addr = 8'h00;
	reg  [7:0] reg_wdata = 8'h00;
	reg        reg_wr = 1'b0;
	reg        reg_rd = 1'b0;
	reg        tx_bit_data = 1'b0;
	reg        tx_bit_frame_start = 1'b0;
	reg        tx_bit_valid = 1'b0;
	reg        run = 1'b0;
	reg        inv = 1'b0;
	reg        uni = 1'b0;
	reg        ami = 1'b0;
	reg        push_d, fr_d, dat_d;
	reg  [7:0] r = 8'h1e;
	reg  [7:0] cfg [0:4];
	wire [7:0] reg_rdata;
	wire       tx_bit_ready, line_clk, pos, neg, clk_out, tick, rx_uni, rx_ami;
	wire       rx_inv, rx_lcd, tx_lcd, refr;
	integer    bad_count = 0;
	integer    samples_checked = 0;
	integer    q [$];
	integer    p [0:3];
	integer    pf [0:3];
	integer    lst, par, pushed, i, m, k, s, kd, ep, en;

	e3tx_line_encoder DUT (.core_clk(core_clk), .rst_n(rst_n), .core_ce(1'b1),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_bit_data(tx_bit_data),
		.tx_bit_frame_start(tx_bit_frame_start), .tx_bit_valid(tx_bit_valid),
		.tx_bit_ready(tx_bit_ready), .tx_line_clock_in(line_clk),
		.tx_positive_rail(pos), .tx_negative_rail(neg),
		.tx_line_clock_out(clk_out), .rx_unipolar_mode(rx_uni),
		.rx_plain_ami(rx_ami), .rx_clock_edge_invert(rx_inv),
		.rx_loc_disable(rx_lcd), .tx_loc_disable(tx_lcd),
		.reframe_request(refr));
	e3tx_liu_model LIU (.core_clk(core_clk), .run(run), .inv(inv),
		.tx_line_clock_out(clk_out), .line_clk(line_clk), .tick(tick));

	always #5 core_clk = ~core_clk;

	function [7:0] lfsr(input [7:0] v);
		lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task check(input [7:0] seen, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks=%0d errors=%0d", samples_checked, bad_count);
			if (bad_count == 0 && samples_checked > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge core_clk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge core_clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] e);
		begin
			@(posedge core_clk);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge core_clk);
			reg_rd <= 1'b0;
			#1 check(reg_rdata, e);
		end
	endtask
	task do_reset;
		begin
			rst_n <= 1'b0;
			repeat (12) @(posedge core_clk);
			rst_n <= 1'b1;
			q.delete();
			lst = 0;
			par = 0;
			push_d = 1'b0;
			pushed = 0;
			for (k = 0; k < 4; k = k + 1) begin
				p[k] = 0;
				pf[k] = 0;
			end
		end
	endtask
	task wt(input integer w);
		begin
			for (i = 0; i < 6000 && (w ? tx_bit_valid || q.size() != 0 :
				tx_bit_ready !== 1'b0); i = i + 1)
				@(posedge core_clk);
			if (i == 6000) begin
				bad_count = bad_count + 1;
				finish_test;
			end
		end
	endtask

	// ****************
	// Line model and stream driver
	// ****************
	always @(posedge core_clk) begin
		if (rst_n) begin
			if (tick === 1'b1) begin
				s = q.size() ? q.pop_front() : 0;
				kd = p[3];
				ep = uni ? kd != 0 : 0;
				en = uni ? pf[3] : 0;
				if (!uni && kd != 0) begin
					if (kd != 3) begin
						lst = !lst;
						par = !par;
					end else
						par = 0;
					ep = lst;
					en = !lst;
				end
				check({6'h00, pos, neg}, {6'h00, ep[0], en[0]});
				for (k = 3; k > 0; k = k - 1) begin
					p[k] = p[k - 1];
					pf[k] = pf[k - 1];
				end
				p[0] = s & 1;
				pf[0] = s >> 1;
				if (!uni && !ami && p[0] + p[1] + p[2] + p[3] == 0) begin
					p[0] = 3;
					if (!par)
						p[3] = 2;
				end
			end
			if (push_d)
				q.push_back({fr_d, dat_d});
			push_d = tx_bit_valid & tx_bit_ready;
			fr_d = tx_bit_frame_start;
			dat_d = tx_bit_data;
			if (push_d) begin
				pushed = pushed + 1;
				r = lfsr(r);
				tx_bit_data <= r[0] & r[1];
				tx_bit_frame_start <= pushed % 32 == 0;
				if (pushed >= 240)
					tx_bit_valid <= 1'b0;
			end
		end
	end

	initial begin
		cfg[0] = 8'ha0;
		cfg[1] = 8'hb0;
		cfg[2] = 8'ha4;
		cfg[3] = 8'ha8;
		cfg[4] = 8'hb8;
		do_reset;
		rd(8'h01, 8'ha0);
		rd(8'h02, 8'h01);
		wr(8'h01, 8'hff);
		rd(8'h01, 8'hbf);
		check({6'h00, rx_uni, rx_ami}, 8'h03);
		check({4'h0, rx_inv, rx_lcd, tx_lcd, refr}, 8'h0f);
		rd(8'h7f, 8'h00);
		for (m = 0; m < 5; m = m + 1) begin
			do_reset;
			wr(8'h01, cfg[m]);
			uni = cfg[m][3];
			ami = cfg[m][4];
			inv = cfg[m][2];
			tx_bit_valid <= 1'b1;
			wt(0);
			check(pushed, 8'h08);
			run = 1'b1;
			wt(1);
			repeat (80) @(posedge core_clk);
			run = 1'b0;
			repeat (40) @(posedge core_clk);
		end
		finish_test;
	end
endmodule // tb
